// ### rtl/config_word_decoder.v
// configuration word loader and decoder with read-only calibration, id and otp words
`timescale 1ns/1ps
`include "config_word_defs.vh"
module config_word_decoder #(
  parameter [23:0] PART_ID_VAL  = 24'h00A5A5, // arbitrary
  parameter [23:0] PART_REV_VAL = 24'h000001  // arbitrary
) (
  input  wire        clk,
  input  wire        rst,
  // non-volatile memory read port
  output reg  [23:0] nvm_addr,
  output reg         nvm_rd,
  input  wire [23:0] nvm_data,
  input  wire        nvm_valid,
  // run-time read-only access
  input  wire        rd_en,
  input  wire [23:0] rd_addr,
  output reg  [23:0] rd_data,
  output reg         rd_valid,
  // otp programming
  input  wire        prog_mode,
  input  wire        prog_we,
  input  wire [5:0]  prog_addr,
  input  wire [23:0] prog_data,
  // run-time status
  input  wire        sw_wdog_enable,
  input  wire        sleep_active,
  input  wire        pll_locked,
  input  wire        aivt_request,
  // decoded outputs
  output reg         load_done,
  output reg  [2:0]  osc_source_sel,
  output reg         fast_rc,
  output reg         fast_rc_div_n,
  output reg         fast_rc_div16,
  output reg         low_power_rc,
  output reg         primary_osc_sel,
  output reg         pll_sel,
  output reg         osc_source_reserved,
  output reg         clk_switch_en,
  output reg         fail_safe_en,
  output reg         pinmap_one_shot_lock,
  output reg         osc_pin_clk_out,
  output reg         osc_pin_gpio,
  output reg         std_crystal_mode,
  output reg         high_speed_crystal_mode,
  output reg         external_clock_mode,
  output reg         primary_osc_off,
  output reg         wdog_run,
  output reg         wdog_rc_keep_on,
  output reg         wdog_sw_ctrl,
  output reg         wdog_windowed,
  output reg  [1:0]  wdog_window_size,
  output reg         pll_clk_ok,
  output reg  [7:0]  wdog_prescale_div,
  output reg  [3:0]  wdog_postscale_sel,
  output reg         i2c_port1_alt_pins,
  output reg         i2c_port2_alt_pins,
  output reg         scan_port_enable,
  output reg  [1:0]  debug_pair_sel,
  output reg         debug_channel_reserved,
  output reg         dac_tie_outputs,
  output reg  [2:0]  alt_regset1_level,
  output reg  [2:0]  alt_regset2_level,
  output reg  [1:0]  flash_boot_mode,
  output reg         aivt_enable
);
  localparam ST_IDLE = 2'd0;
  localparam ST_REQ  = 2'd1;
  localparam ST_WAIT = 2'd2;
  localparam ST_DONE = 2'd3;

  reg  [1:0]  state_reg;
  reg  [2:0]  idx_reg;
  reg  [23:0] oscsel_reg, osc_reg, wdt_reg, icd_reg, devopt_reg, altreg_reg;
  reg  [23:0] sec_reg, boot_reg;
  reg  [23:0] amp1_trim_word, amp2_trim_word, current_source_trim_word;
  reg         rd_pend_reg;
  reg  [23:0] rd_addr_reg;
  wire [23:0] otp_data;
  reg  [23:0] idx_addr;

  always @* begin
    case (idx_reg)
      3'd0:    idx_addr = `ADDR_FOSCSEL_W;
      3'd1:    idx_addr = `ADDR_FOSC_W;
      3'd2:    idx_addr = `ADDR_FWDT_W;
      3'd3:    idx_addr = `ADDR_FICD_W;
      3'd4:    idx_addr = `ADDR_FDEVOPT_W;
      3'd5:    idx_addr = `ADDR_FALTREG_W;
      3'd6:    idx_addr = `ADDR_FSEC_W;
      default: idx_addr = `ADDR_FBOOT_W;
    endcase
  end

  // every reset reloads all words; shadows sit at erased values meanwhile
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg  <= ST_IDLE;
      idx_reg    <= 3'd0;
      nvm_addr   <= 24'h000000;
      nvm_rd     <= 1'b0;
      load_done  <= 1'b0;
      oscsel_reg <= `SAFE_WORD;
      osc_reg    <= `SAFE_WORD;
      wdt_reg    <= `SAFE_WORD;
      icd_reg    <= `SAFE_WORD;
      devopt_reg <= `SAFE_WORD;
      altreg_reg <= `SAFE_WORD;
      sec_reg    <= `SAFE_WORD;
      boot_reg   <= `SAFE_WORD;
    end else begin
      nvm_rd <= 1'b0;
      case (state_reg)
        ST_IDLE: state_reg <= ST_REQ;
        ST_REQ: begin
          nvm_addr  <= idx_addr;
          nvm_rd    <= 1'b1;
          state_reg <= ST_WAIT;
        end
        ST_WAIT: if (nvm_valid) begin
          case (idx_reg)
            3'd0:    oscsel_reg <= nvm_data;
            3'd1:    osc_reg    <= nvm_data;
            3'd2:    wdt_reg    <= nvm_data;
            3'd3:    icd_reg    <= nvm_data;
            3'd4:    devopt_reg <= nvm_data;
            3'd5:    altreg_reg <= nvm_data;
            3'd6:    sec_reg    <= nvm_data;
            default: boot_reg   <= nvm_data;
          endcase
          if (idx_reg == 3'd7) begin
            state_reg <= ST_DONE;
            load_done <= 1'b1;
          end else begin
            idx_reg   <= idx_reg + 3'd1;
            state_reg <= ST_REQ;
          end
        end
        ST_DONE: state_reg <= ST_DONE;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // field extraction
  wire [2:0] f_src   = oscsel_reg[`F_OSC_SRC_LO+2:`F_OSC_SRC_LO];
  wire [1:0] f_pri   = osc_reg[`F_PRI_MODE_LO+1:`F_PRI_MODE_LO];
  wire [1:0] f_csw   = osc_reg[`F_CLK_SW_LO+1:`F_CLK_SW_LO];
  wire [1:0] f_wen   = wdt_reg[`F_WD_EN_LO+1:`F_WD_EN_LO];
  wire [1:0] f_win   = wdt_reg[`F_WD_WIN_LO+1:`F_WD_WIN_LO];
  wire [3:0] f_post  = wdt_reg[`F_WD_POST_LO+3:`F_WD_POST_LO];
  wire [1:0] f_dbg   = icd_reg[`F_DBG_CH_LO+1:`F_DBG_CH_LO];
  wire [2:0] f_ctx1  = altreg_reg[`F_REGSET1_LO+2:`F_REGSET1_LO];
  wire [2:0] f_ctx2  = altreg_reg[`F_REGSET2_LO+2:`F_REGSET2_LO];
  wire       crystal = (f_pri == 2'b10) || (f_pri == 2'b01);

  // decoded outputs update only while load_done is high; word fields then hold until reset, but wdog_run, pll_clk_ok and aivt_enable keep tracking inputs
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_source_sel <= 3'b000;
      fast_rc <= 1'b1;
      fast_rc_div_n <= 1'b0;
      fast_rc_div16 <= 1'b0;
      low_power_rc <= 1'b0;
      primary_osc_sel <= 1'b0;
      pll_sel <= 1'b0;
      osc_source_reserved <= 1'b0;
      clk_switch_en <= 1'b0;
      fail_safe_en <= 1'b0;
      pinmap_one_shot_lock <= 1'b1;
      osc_pin_clk_out <= 1'b0;
      osc_pin_gpio <= 1'b0;
      std_crystal_mode <= 1'b0;
      high_speed_crystal_mode <= 1'b0;
      external_clock_mode <= 1'b0;
      primary_osc_off <= 1'b1;
      wdog_run <= 1'b0;
      wdog_rc_keep_on <= 1'b0;
      wdog_sw_ctrl <= 1'b0;
      wdog_windowed <= 1'b0;
      wdog_window_size <= 2'b00;
      pll_clk_ok <= 1'b0;
      wdog_prescale_div <= 8'h80;
      wdog_postscale_sel <= 4'hF;
      i2c_port1_alt_pins <= 1'b0;
      i2c_port2_alt_pins <= 1'b0;
      scan_port_enable <= 1'b0;
      debug_pair_sel <= 2'b00;
      debug_channel_reserved <= 1'b0;
      dac_tie_outputs <= 1'b0;
      alt_regset1_level <= 3'b000;
      alt_regset2_level <= 3'b000;
      flash_boot_mode <= 2'b11;
      aivt_enable <= 1'b0;
    end else if (load_done) begin
      osc_source_sel <= f_src;
      fast_rc <= (f_src == 3'b000);
      fast_rc_div_n <= (f_src == 3'b111) || (f_src == 3'b001);
      fast_rc_div16 <= (f_src == 3'b110);
      low_power_rc <= (f_src == 3'b101);
      primary_osc_sel <= (f_src == 3'b010) || (f_src == 3'b011);
      pll_sel <= (f_src == 3'b011) || (f_src == 3'b001);
      osc_source_reserved <= (f_src == 3'b100);
      clk_switch_en <= ~f_csw[1];
      fail_safe_en <= (f_csw == 2'b00);
      pinmap_one_shot_lock <= osc_reg[`F_PINMAP_LOCK];
      osc_pin_clk_out <= ~crystal & osc_reg[`F_OSC_PIN_FN];
      osc_pin_gpio <= ~crystal & ~osc_reg[`F_OSC_PIN_FN];
      high_speed_crystal_mode <= (f_pri == 2'b10);
      std_crystal_mode <= (f_pri == 2'b01);
      external_clock_mode <= (f_pri == 2'b00);
      primary_osc_off <= (f_pri == 2'b11);
      case (f_wen)
        2'b11: wdog_run <= 1'b1;
        2'b10: wdog_run <= sw_wdog_enable;
        2'b01: wdog_run <= ~sleep_active;
        default: wdog_run <= 1'b0;
      endcase
      wdog_rc_keep_on <= (f_wen == 2'b11);
      wdog_sw_ctrl <= (f_wen == 2'b10);
      wdog_windowed <= ~wdt_reg[`F_WD_WIN_DIS];
      wdog_window_size <= f_win;
      // pll lock honoured only when enabled
      pll_clk_ok <= ~osc_reg[`F_PLL_LOCK_EN] | pll_locked;
      wdog_prescale_div <= wdt_reg[`F_WD_PRE] ? 8'h80 : 8'h20;
      wdog_postscale_sel <= f_post;
      i2c_port1_alt_pins <= ~devopt_reg[`F_I2C1_ALT];
      i2c_port2_alt_pins <= ~devopt_reg[`F_I2C2_ALT];
      scan_port_enable <= icd_reg[`F_SCAN_EN];
      debug_pair_sel <= 2'd3 - f_dbg + 2'd1;
      debug_channel_reserved <= (f_dbg == 2'b00);
      dac_tie_outputs <= ~devopt_reg[`F_DAC_XC];
      alt_regset1_level <= (f_ctx1 == 3'b111) ? 3'b000 : f_ctx1 + 3'd1;
      alt_regset2_level <= (f_ctx2 == 3'b111) ? 3'b000 : f_ctx2 + 3'd1;
      flash_boot_mode <= boot_reg[`F_BOOT_MODE_LO+1:`F_BOOT_MODE_LO];
      aivt_enable <= ~sec_reg[`F_BSEG_DISABLE] & ~sec_reg[`F_AIVT_DISABLE]
                     & aivt_request;
    end
  end

  otp_word_store #(
    .WORDS (64),
    .AW    (6),
    .DW    (24)
  ) u_otp (
    .clk       (clk),
    .rst       (rst),
    .prog_mode (prog_mode),
    .prog_we   (prog_we),
    .prog_addr (prog_addr),
    .prog_data (prog_data),
    .rd_addr   (rd_addr[6:1]),
    .rd_data   (otp_data)
  );

  // trim words are never loaded from memory; all three stay at zero
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      amp1_trim_word           <= 24'h000000;
      amp2_trim_word           <= 24'h000000;
      current_source_trim_word <= 24'h000000;
    end else if (nvm_valid && state_reg == ST_WAIT) begin
      if (idx_reg == 3'd0)
        amp1_trim_word <= 24'h000000;
    end
  end

  // two-cycle read: otp array output lands one edge after the address
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_pend_reg <= 1'b0;
      rd_addr_reg <= 24'h000000;
      rd_data     <= 24'h000000;
      rd_valid    <= 1'b0;
    end else begin
      rd_pend_reg <= rd_en & ~rd_pend_reg;
      if (rd_en & ~rd_pend_reg)
        rd_addr_reg <= rd_addr;
      rd_valid <= rd_pend_reg;
      if (rd_pend_reg) begin
        if (rd_addr_reg >= `ADDR_OTP_FIRST && rd_addr_reg <= `ADDR_OTP_LAST)
          rd_data <= otp_data;
        else begin
          case (rd_addr_reg)
            `ADDR_AMP1_TRIM: rd_data <= amp1_trim_word;
            `ADDR_AMP2_TRIM: rd_data <= amp2_trim_word;
            `ADDR_ISRC_TRIM: rd_data <= current_source_trim_word;
            `ADDR_PART_ID:   rd_data <= PART_ID_VAL;
            `ADDR_PART_REV:  rd_data <= PART_REV_VAL;
            default:         rd_data <= 24'h000000;
          endcase
        end
      end
    end
  end
endmodule // config_word_decoder

// ### rtl/config_word_defs.vh
// constants for the configuration word decoder: addresses, field positions, reset values
`ifndef CONFIG_WORD_DEFS_VH
`define CONFIG_WORD_DEFS_VH

// configuration word addresses (two address units per word, 24-bit words)
`define ADDR_FOSCSEL_W     24'h005798
`define ADDR_FOSC_W        24'h00579C
`define ADDR_FWDT_W        24'h0057A0
`define ADDR_FICD_W        24'h0057A8
`define ADDR_FDEVOPT_W     24'h0057AC
`define ADDR_FALTREG_W     24'h0057B0
`define ADDR_FSEC_W        24'h005780
`define ADDR_FBOOT_W       24'h801000
`define ADDR_AMP1_TRIM     24'h800E48
`define ADDR_AMP2_TRIM     24'h800E4C
`define ADDR_ISRC_TRIM     24'h800E78
`define ADDR_PART_ID       24'hFF0000
`define ADDR_PART_REV      24'hFF0002
`define ADDR_OTP_FIRST     24'h800F80
`define ADDR_OTP_LAST      24'h800FFE

// field positions
`define F_OSC_SRC_LO       0
`define F_PRI_MODE_LO      0
`define F_OSC_PIN_FN       2
`define F_PINMAP_LOCK      5
`define F_CLK_SW_LO        6
`define F_PLL_LOCK_EN      8
`define F_WD_POST_LO       0
`define F_WD_PRE           4
`define F_WD_EN_LO         5
`define F_WD_WIN_DIS       7
`define F_WD_WIN_LO        8
`define F_DBG_CH_LO        0
`define F_SCAN_EN          5
`define F_I2C1_ALT         3
`define F_I2C2_ALT         4
`define F_DAC_XC           6
`define F_REGSET1_LO       0
`define F_REGSET2_LO       4
`define F_BOOT_MODE_LO     0
`define F_BSEG_DISABLE     3
`define F_AIVT_DISABLE     15

// safe defaults held while loading (erased flash reads as all ones)
`define SAFE_WORD          24'hFFFFFF

// loader sequence length
`define LOAD_WORDS         8

`endif

// ### rtl/otp_word_store.v
// one-time-programmable user word array, written once per reset in programming mode, read-only at run time
`timescale 1ns/1ps
module otp_word_store #(
  parameter WORDS = 64,
  parameter AW    = 6,
  parameter DW    = 24
) (
  input  wire          clk,
  input  wire          rst,
  input  wire          prog_mode,
  input  wire          prog_we,
  input  wire [AW-1:0] prog_addr,
  input  wire [DW-1:0] prog_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);
  reg [DW-1:0]    mem [0:WORDS-1];
  reg [WORDS-1:0] burnt_reg;

  // only programming mode may write, and each word only once between resets
  always @(posedge clk) begin
    if (prog_mode && prog_we && !burnt_reg[prog_addr])
      mem[prog_addr] <= prog_data;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      burnt_reg <= {WORDS{1'b0}};
      rd_data   <= {DW{1'b0}};
    end else begin
      if (prog_mode && prog_we)
        burnt_reg[prog_addr] <= 1'b1;
      rd_data <= burnt_reg[rd_addr] ? mem[rd_addr] : {DW{1'b1}};
    end
  end
endmodule // otp_word_store

// ### testbench/config_word_decoder_bench.sv
// self-checking bench for the configuration word decoder
`timescale 1ns/1ps
`include "config_word_defs.vh"
module config_word_decoder_bench;
  localparam [23:0] PART_ID_VAL  = 24'h0C0DE1; // arbitrary
  localparam [23:0] PART_REV_VAL = 24'h000007; // arbitrary
  reg          clk, rst, nvm_valid, rd_en, prog_mode, prog_we;
  reg          sw_wdog_enable, sleep_active, pll_locked, aivt_request;
  reg  [23:0]  nvm_data, rd_addr, prog_data;
  reg  [5:0]   prog_addr;
  reg  [1:0]   nvm_cnt;
  reg  [191:0] img;
  integer      num_errors, cmp_count, cycles;
  wire [23:0]  nvm_addr, rd_data;
  wire [7:0]   wdog_prescale_div;
  wire [3:0]   wdog_postscale_sel;
  wire [2:0]   osc_source_sel, alt_regset1_level, alt_regset2_level;
  wire [1:0]   wdog_window_size, debug_pair_sel, flash_boot_mode;
  wire         nvm_rd, rd_valid, load_done, fast_rc, fast_rc_div_n, fast_rc_div16;
  wire         low_power_rc, primary_osc_sel, pll_sel, osc_source_reserved, clk_switch_en;
  wire         fail_safe_en, pinmap_one_shot_lock, osc_pin_clk_out, osc_pin_gpio;
  wire         std_crystal_mode, high_speed_crystal_mode, external_clock_mode;
  wire         primary_osc_off, wdog_run, wdog_rc_keep_on, wdog_sw_ctrl, wdog_windowed;
  wire         pll_clk_ok, i2c_port1_alt_pins, i2c_port2_alt_pins, scan_port_enable;
  wire         debug_channel_reserved, dac_tie_outputs, aivt_enable;

  config_word_decoder #(.PART_ID_VAL(PART_ID_VAL), .PART_REV_VAL(PART_REV_VAL))
    u_config_word_decoder (.*);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function [23:0] img_word(input [23:0] a);
    case (a)
      `ADDR_FOSCSEL_W: img_word = img[23:0];
      `ADDR_FOSC_W:    img_word = img[47:24];
      `ADDR_FWDT_W:    img_word = img[71:48];
      `ADDR_FICD_W:    img_word = img[95:72];
      `ADDR_FDEVOPT_W: img_word = img[119:96];
      `ADDR_FALTREG_W: img_word = img[143:120];
      `ADDR_FSEC_W:    img_word = img[167:144];
      `ADDR_FBOOT_W:   img_word = img[191:168];
      default:         img_word = 24'hFFFFFF;
    endcase
  endfunction

  // memory answers two cycles after a fetch; data line scrambles when idle
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      end_of_test;
    end
    nvm_valid <= #2 (nvm_cnt == 2'd1);
    nvm_data  <= #2 (nvm_cnt == 2'd1) ? img_word(nvm_addr) : ~nvm_data;
    nvm_cnt   <= nvm_rd ? 2'd2 : nvm_cnt - (nvm_cnt != 2'd0);
  end

  task end_of_test;
    begin
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  task chk(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #2;
    end
  endtask

  task load(input [191:0] w);
    integer k;
    begin
      img = w;
      rst = 1'b1;
      tick(20);
      chk({fast_rc, primary_osc_off, load_done, flash_boot_mode}, 5'b11011);
      rst = 1'b0;
      for (k = 0; k < 200 && load_done !== 1'b1; k = k + 1) tick(1);
      tick(3);
    end
  endtask

  task rd(input [23:0] a, input [23:0] exp);
    integer k;
    begin
      rd_addr = a;
      rd_en = 1'b1;
      tick(1);
      rd_en = 1'b0;
      for (k = 0; k < 4 && rd_valid !== 1'b1; k = k + 1) tick(1);
      chk({rd_valid, rd_data}, {1'b1, exp});
      tick(2);
    end
  endtask

  task prog(input m, input [5:0] a, input [23:0] d);
    begin
      prog_mode = m;
      prog_we = 1'b1;
      prog_addr = a;
      prog_data = d;
      tick(1);
      prog_we = 1'b0;
      prog_mode = 1'b0;
      tick(1);
    end
  endtask

  task t_image_a;
    begin
      load({24'h0, 24'h0, 24'h76, 24'h08, 24'h21, 24'h35F, 24'h125, 24'h4});
      chk({osc_source_reserved, low_power_rc, osc_source_sel}, 5'h14);
      chk({clk_switch_en, fail_safe_en, pinmap_one_shot_lock}, 3'b111);
      chk({std_crystal_mode, osc_pin_clk_out, osc_pin_gpio}, 3'b100);
      chk({wdog_windowed, wdog_window_size, wdog_postscale_sel}, 7'h7F);
      chk({wdog_prescale_div, aivt_enable}, 9'h101);
      chk({debug_pair_sel, debug_channel_reserved, scan_port_enable}, 4'hD);
      chk({i2c_port1_alt_pins, i2c_port2_alt_pins, dac_tie_outputs}, 3'b011);
      chk({alt_regset1_level, alt_regset2_level, flash_boot_mode}, 8'hE0);
      sw_wdog_enable = 1'b0;
      pll_locked = 1'b0;
      tick(2);
      chk({wdog_sw_ctrl, wdog_run, pll_clk_ok}, 3'b100);
      sw_wdog_enable = 1'b1;
      pll_locked = 1'b1;
      aivt_request = 1'b0;
      tick(2);
      chk({wdog_run, pll_clk_ok, aivt_enable}, 3'b110);
      aivt_request = 1'b1;
      tick(2);
      chk(aivt_enable, 1'b1);
    end
  endtask

  task t_image_b;
    begin
      load({24'h3, 24'h8, 24'h50, 24'h50, 24'h2, 24'hE0, 24'h44, 24'h5});
      chk({low_power_rc, osc_source_reserved, osc_source_sel}, 5'h15);
      chk({clk_switch_en, fail_safe_en, pinmap_one_shot_lock}, 3'b100);
      chk({external_clock_mode, osc_pin_clk_out, osc_pin_gpio}, 3'b110);
      chk({wdog_windowed, wdog_window_size, wdog_postscale_sel}, 7'h00);
      chk(wdog_prescale_div, 8'h20);
      chk({debug_pair_sel, scan_port_enable}, 3'b100);
      chk({i2c_port1_alt_pins, i2c_port2_alt_pins, dac_tie_outputs}, 3'b100);
      chk({alt_regset1_level, alt_regset2_level, flash_boot_mode}, 8'h3B);
      sw_wdog_enable = 1'b0;
      pll_locked = 1'b0;
      tick(2);
      chk({wdog_rc_keep_on, wdog_run, pll_clk_ok, aivt_enable}, 4'hE);
      sw_wdog_enable = 1'b1;
      pll_locked = 1'b1;
    end
  endtask

  task t_wdog_modes;
    begin
      load({24'h0, 24'h0, 24'h76, 24'h08, 24'h21, 24'h020, 24'h125, 24'h3});
      sleep_active = 1'b1;
      tick(2);
      chk({wdog_sw_ctrl, wdog_run, pll_sel, fast_rc}, 4'b0010);
      sleep_active = 1'b0;
      tick(2);
      chk(wdog_run, 1'b1);
      // reset again after the load has finished, then once more while the loader is mid-sequence
      rst = 1'b1;
      tick(1);
      rst = 1'b0;
      tick(6);
      load({24'h0, 24'h0, 24'h76, 24'h08, 24'h21, 24'h000, 24'h125, 24'h6});
      chk({wdog_run, wdog_sw_ctrl, wdog_rc_keep_on, fast_rc_div16}, 4'b0001);
    end
  endtask

  // divide-by-n source, high-speed crystal, pair 1 debug, vector table disabled
  task t_image_c;
    begin
      load({24'h1, 24'h8000, 24'h0, 24'h18, 24'h3, 24'h1A, 24'h86, 24'h7});
      chk({fast_rc_div_n, pll_sel, primary_osc_sel, fast_rc, primary_osc_off}, 5'h10);
      chk({high_speed_crystal_mode, osc_pin_clk_out, osc_pin_gpio}, 3'b100);
      chk({clk_switch_en, fail_safe_en, pinmap_one_shot_lock}, 3'b000);
      chk({wdog_windowed, wdog_window_size, wdog_postscale_sel}, 7'h4A);
      chk({wdog_prescale_div, wdog_run}, 9'h100);
      chk({debug_pair_sel, debug_channel_reserved, i2c_port1_alt_pins}, 4'b0100);
      chk({i2c_port2_alt_pins, dac_tie_outputs}, 2'b01);
      chk({alt_regset1_level, alt_regset2_level, flash_boot_mode}, 8'h25);
      chk(aivt_enable, 1'b0);
    end
  endtask

  task t_reads;
    begin
      rd(`ADDR_AMP1_TRIM, 24'h0);
      rd(`ADDR_ISRC_TRIM, 24'h0);
      rd(`ADDR_PART_ID, PART_ID_VAL);
      rd(`ADDR_PART_REV, PART_REV_VAL);
      rd(24'h800F7E, 24'h0);
      rd(`ADDR_OTP_LAST, 24'hFFFFFF);
      prog(1'b1, 6'd5, 24'h123456);
      prog(1'b1, 6'd5, 24'h654321);
      prog(1'b0, 6'd6, 24'h000000);
      rd(`ADDR_OTP_FIRST + 24'hA, 24'h123456);
      rd(`ADDR_OTP_FIRST + 24'hC, 24'hFFFFFF);
    end
  endtask

  initial begin
    num_errors = 0;
    cmp_count = 0;
    cycles = 0;
    nvm_cnt = 2'd0;
    rst = 1'b1;
    nvm_valid = 1'b0;
    nvm_data = 24'h0;
    rd_en = 1'b0;
    rd_addr = 24'h0;
    prog_mode = 1'b0;
    prog_we = 1'b0;
    prog_addr = 6'h0;
    prog_data = 24'h0;
    sw_wdog_enable = 1'b1;
    sleep_active = 1'b0;
    pll_locked = 1'b1;
    aivt_request = 1'b1;
    img = 192'h0;
    t_image_a;
    t_image_b;
    t_wdog_modes;
    t_image_c;
    t_reads;
    end_of_test;
  end
endmodule // config_word_decoder_bench

// ### testbench/config_word_decoder_sva.sv
// assertion checker for the configuration word decoder
`timescale 1ns/1ps
`include "config_word_defs.vh"
module config_word_decoder_sva (
  input wire        clk,
  input wire        rst,
  input wire [23:0] nvm_addr,
  input wire        nvm_rd,
  input wire [23:0] nvm_data,
  input wire        nvm_valid,
  input wire        rd_en,
  input wire        rd_valid,
  input wire        sw_wdog_enable,
  input wire        pll_locked,
  input wire        load_done,
  input wire [2:0]  osc_source_sel,
  input wire        osc_source_reserved,
  input wire        fast_rc,
  input wire        primary_osc_off,
  input wire        wdog_run,
  input wire        wdog_rc_keep_on,
  input wire        wdog_sw_ctrl,
  input wire        pll_clk_ok,
  input wire [7:0]  wdog_prescale_div,
  input wire [1:0]  flash_boot_mode,
  input wire [2:0]  alt_regset1_level,
  input wire        aivt_enable
);
  reg [23:0] fosc_cap;
  reg [23:0] fwdt_cap;
  reg [23:0] falt_cap;
  reg [23:0] fsec_cap;
  wire [1:0] wd_mode = fwdt_cap[`F_WD_EN_LO +: 2];

  // shadow of four fetched words (FOSC, FWDT, FALTREG, FSEC), so decodes are judged against the source
  always @(posedge clk) begin
    if (nvm_valid && nvm_addr == `ADDR_FOSC_W) fosc_cap <= nvm_data;
    if (nvm_valid && nvm_addr == `ADDR_FWDT_W) fwdt_cap <= nvm_data;
    if (nvm_valid && nvm_addr == `ADDR_FALTREG_W) falt_cap <= nvm_data;
    if (nvm_valid && nvm_addr == `ADDR_FSEC_W) fsec_cap <= nvm_data;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_first_fetch; $fell(rst) |-> ##[0:3] (nvm_rd && nvm_addr == `ADDR_FOSCSEL_W); endproperty
  a_first_fetch: assert property (p_first_fetch) else $error("no first fetch");
  property p_safe; !load_done |-> fast_rc && primary_osc_off && !wdog_run
    && wdog_prescale_div == 8'h80 && flash_boot_mode == 2'b11; endproperty
  a_safe: assert property (p_safe) else $error("outputs not safe while loading");
  property p_hold; $past(load_done, 2) && load_done |-> $stable({osc_source_sel,
    wdog_prescale_div, flash_boot_mode, alt_regset1_level, wdog_rc_keep_on}); endproperty
  a_hold: assert property (p_hold) else $error("decode changed after load");
  property p_reserved; load_done |-> osc_source_reserved == (osc_source_sel == 3'h4); endproperty
  a_reserved: assert property (p_reserved) else $error("reserved source flag wrong");
  property p_prescale; $past(load_done) && load_done
    |-> wdog_prescale_div == (fwdt_cap[`F_WD_PRE] ? 8'h80 : 8'h20); endproperty
  a_prescale: assert property (p_prescale) else $error("prescale ratio wrong");
  property p_forced; $past(load_done) && load_done && wd_mode == 2'b11
    |-> wdog_run && wdog_rc_keep_on; endproperty
  a_forced: assert property (p_forced) else $error("watchdog not forced on");
  property p_sw; $past(load_done, 2) && load_done && wd_mode == 2'b10
    |-> wdog_run == $past(sw_wdog_enable) && wdog_sw_ctrl; endproperty
  a_sw: assert property (p_sw) else $error("software watchdog control wrong");
  property p_off; $past(load_done) && load_done && wd_mode == 2'b00
    |-> !wdog_run && !wdog_sw_ctrl; endproperty
  a_off: assert property (p_off) else $error("watchdog not disabled");
  property p_pll; $past(load_done, 2) && load_done
    |-> pll_clk_ok == (!fosc_cap[`F_PLL_LOCK_EN] || $past(pll_locked)); endproperty
  a_pll: assert property (p_pll) else $error("pll lock gating wrong");
  property p_regset; $past(load_done) && load_done |-> alt_regset1_level
    == ((falt_cap[2:0] == 3'h7) ? 3'h0 : falt_cap[2:0] + 3'h1); endproperty
  a_regset: assert property (p_regset) else $error("register set level wrong");
  property p_aivt; load_done && aivt_enable |-> !fsec_cap[`F_BSEG_DISABLE]; endproperty
  a_aivt: assert property (p_aivt) else $error("vector table without boot segment");
  property p_rd; rd_en |-> ##2 rd_valid ##1 !rd_valid; endproperty
  a_rd: assert property (p_rd) else $error("read answer timing wrong");
endmodule // config_word_decoder_sva

bind config_word_decoder config_word_decoder_sva u_config_word_decoder_sva (.*);
